// file: bcs_pkg.sv
package bcs_pkg;

  // ==========================================================================
  // Instruction word layout
  localparam int          BCS_WORD_W    = 14;
  localparam int          BCS_BIT_W     = 3;
  localparam int          BCS_ADDR_W    = 7;
  localparam int          BCS_DATA_W    = 8;
  localparam int          BCS_OP_HI     = 13;
  localparam int          BCS_OP_LO     = 10;
  localparam int          BCS_BSEL_HI   = 9;
  localparam int          BCS_BSEL_LO   = 7;
  localparam int          BCS_ADDR_HI   = 6;
  localparam int          BCS_ADDR_LO   = 0;
  localparam logic [3:0]  BCS_OP_CLEAR  = 4'h4;
  localparam logic [3:0]  BCS_OP_TSKIP  = 4'h6;

  // ==========================================================================
  // Quarter phases of one instruction cycle
  localparam logic [1:0]  BCS_Q1        = 2'h0;
  localparam logic [1:0]  BCS_Q2        = 2'h1;
  localparam logic [1:0]  BCS_Q3        = 2'h2;
  localparam logic [1:0]  BCS_Q4        = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [13:0] BCS_IR_RESET  = 14'h0000;
  localparam logic [7:0]  BCS_DATA_RST  = 8'h00;

  typedef enum logic [1:0] {
    BCS_NONE,
    BCS_CLEAR,
    BCS_TSKIP
  } bcs_op_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic       wr;
  } bcs_file_wr_t;

endpackage

// file: bcs_bit_mask.sv
`timescale 1ns/10ps
module bcs_bit_mask #(
  parameter int DATA_W = 8,
  parameter int SEL_W  = 3
) (
  // Select and operand
  input  wire logic [SEL_W-1:0]  sel_in,
  input  wire logic [DATA_W-1:0] data_in,
  // Results
  output logic      [DATA_W-1:0] cleared_out,
  output logic                   bit_out
);

  logic [DATA_W-1:0] onehot;

  always_comb
  begin
    onehot      = '0;
    onehot[sel_in] = 1'b1;
    cleared_out = data_in & ~onehot;
    bit_out     = |(data_in & onehot);
  end

endmodule

// file: bcs_bit_ops.sv
// Notes on behaviour
// - Clear zeroes the selected bit, others kept
// - Clear decoded from top bits 0100
// - Test-skip decoded from top bits 0110
// - Tested bit one: next executes normally
// - Tested bit zero: next discarded, NOP
// - Skip takes two cycles, else one
`timescale 1ns/10ps
module bcs_bit_ops
  import bcs_pkg::*;
#(
  parameter int WORD_W = 14,
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  // Instruction in, latched at Q1 of each cycle
  input  wire logic [WORD_W-1:0]        instr_in,
  // Register file read port
  output logic      [ADDR_W-1:0]        rd_addr_out,
  input  wire logic [DATA_W-1:0]        rd_data_in,
  // Register file write port
  output bcs_pkg::bcs_file_wr_t         file_wr_out,
  // Phase and pipeline control
  output logic      [1:0]               phase_out,
  output logic                          cycle_end_out,
  output logic                          flush_out,
  output logic                          nop_cycle_out,
  output logic                          busy_out
);

  import bcs_pkg::*;

  // ==========================================================================
  // Quarter-phase counter: one instruction cycle is four clocks
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic       at_q1;
  logic       at_q2;
  logic       at_q3;
  logic       at_q4;

  // Free-running; reset always restarts at Q1
  always_comb
  begin
    phase_d = phase_q + 2'h1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      phase_q <= BCS_Q1;
    else
      phase_q <= phase_d;
  end

  assign at_q1         = (phase_q == BCS_Q1);
  assign at_q2         = (phase_q == BCS_Q2);
  assign at_q3         = (phase_q == BCS_Q3);
  assign at_q4         = (phase_q == BCS_Q4);
  assign phase_out     = phase_q;
  assign cycle_end_out = at_q4;

  // ==========================================================================
  // Decode at Q1
  logic [3:0]        op_field;
  logic [WORD_W-1:0] ir_q;
  logic [WORD_W-1:0] ir_d;
  bcs_op_t           op_d;
  bcs_op_t           op_next;
  bcs_op_t           op_q;
  logic              skip_q;
  logic              skip_d;

  assign op_field = instr_in[BCS_OP_HI:BCS_OP_LO];

  always_comb
  begin
    unique case (op_field)
      BCS_OP_CLEAR: op_d = BCS_CLEAR;
      BCS_OP_TSKIP: op_d = BCS_TSKIP;
      default:      op_d = BCS_NONE;
    endcase
  end

  // A word fetched behind a taken skip is run as a no-operation
  always_comb
  begin
    ir_d    = ir_q;
    op_next = op_q;
    if (at_q1)
    begin
      ir_d    = instr_in;
      op_next = skip_q ? BCS_NONE : op_d;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ir_q <= BCS_IR_RESET;
    else
      ir_q <= ir_d;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      op_q <= BCS_NONE;
    else
      op_q <= op_next;
  end

  // ==========================================================================
  // Read register at Q2, process at Q3
  logic [BCS_BIT_W-1:0] bsel;
  logic [DATA_W-1:0]    data_d;
  logic [DATA_W-1:0]    data_q;
  logic [DATA_W-1:0]    cleared;
  logic                 tested;

  assign bsel        = ir_q[BCS_BSEL_HI:BCS_BSEL_LO];
  assign rd_addr_out = ir_q[BCS_ADDR_HI:BCS_ADDR_LO];

  // Operand captured once, so the file may change after Q2
  always_comb
  begin
    data_d = data_q;
    if (at_q2)
      data_d = rd_data_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      data_q <= BCS_DATA_RST;
    else
      data_q <= data_d;
  end

  bcs_bit_mask #(
    .DATA_W (DATA_W),
    .SEL_W  (BCS_BIT_W)
  ) i_bcs_bit_mask (
    .sel_in      (bsel),
    .data_in     (data_q),
    .cleared_out (cleared),
    .bit_out     (tested)
  );

  // ==========================================================================
  // Write back at Q4; flags are never touched by either operation
  bcs_file_wr_t file_wr_d;

  // Address and data hold after the strobe drops
  always_comb
  begin
    file_wr_d    = file_wr_out;
    file_wr_d.wr = 1'b0;
    if (at_q3 && op_q == BCS_CLEAR)
    begin
      file_wr_d.addr = ir_q[BCS_ADDR_HI:BCS_ADDR_LO];
      file_wr_d.data = cleared;
      file_wr_d.wr   = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      file_wr_out <= '0;
    else
      file_wr_out <= file_wr_d;
  end

  // ==========================================================================
  // Skip decision: made at Q3, consumed at the next Q1
  logic nop_d;
  logic nop_q;

  always_comb
  begin
    skip_d = skip_q;
    if (at_q3)
      skip_d = (op_q == BCS_TSKIP) && !tested;
    else if (at_q1)
      skip_d = 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      skip_q <= 1'b0;
    else
      skip_q <= skip_d;
  end

  // Second cycle of a taken skip is the NOP cycle
  always_comb
  begin
    nop_d = nop_q;
    if (at_q1)
      nop_d = skip_q;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      nop_q <= 1'b0;
    else
      nop_q <= nop_d;
  end

  // ==========================================================================
  // Pipeline control outputs
  // Fetcher drops its prefetched word while this is high
  assign flush_out     = skip_q && at_q4;
  assign nop_cycle_out = nop_q;
  // Busy also covers the NOP cycle so a stalling fetcher sees it
  assign busy_out      = (op_q != BCS_NONE) || nop_q;

endmodule

// file: bcs_bit_ops_chk.sv
`timescale 1ns/10ps
module bcs_bit_ops_chk
  import bcs_pkg::*;
(
  // Watched ports
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic [13:0]           instr_in,
  input wire logic [6:0]            rd_addr_out,
  input wire logic [7:0]            rd_data_in,
  input wire bcs_pkg::bcs_file_wr_t file_wr_out,
  input wire logic [1:0]            phase_out,
  input wire logic                  cycle_end_out,
  input wire logic                  flush_out,
  input wire logic                  nop_cycle_out,
  input wire logic                  busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // A word taken right after a flush is refused
  sequence take_clr;
    phase_out == 2'h0 && instr_in[13:10] == 4'h4 && !$past(flush_out);
  endsequence
  sequence nop_cycle;
    nop_cycle_out [*4] ##1 !nop_cycle_out;
  endsequence
  a_clr_write: assert property (take_clr |-> ##3 file_wr_out.wr)
    else $error("clear not written");
  a_clr_data: assert property (file_wr_out.wr |->
    file_wr_out.addr == $past(instr_in[6:0], 3) &&
    file_wr_out.data == ($past(rd_data_in, 2) & ~(8'h01 << $past(instr_in[9:7], 3))))
    else $error("bad clear data");
  a_wr_cause: assert property (file_wr_out.wr |-> phase_out == 2'h3 &&
    $past(instr_in[13:10], 3) == 4'h4 && !$past(flush_out, 4))
    else $error("stray write");
  a_skip_flush: assert property (phase_out == 2'h3 && !$past(flush_out, 4) &&
    $past(instr_in[13:10], 3) == 4'h6 |->
    flush_out == !(($past(rd_data_in, 2) >> $past(instr_in[9:7], 3)) & 8'h01))
    else $error("skip decision wrong");
  a_flush_cause: assert property (flush_out |-> $past(instr_in[13:10], 3) == 4'h6)
    else $error("stray flush");
  a_nop_span: assert property (flush_out |-> ##2 nop_cycle)
    else $error("nop cycle length");
  a_nop_quiet: assert property (nop_cycle_out |-> !file_wr_out.wr && !flush_out)
    else $error("nop cycle acted");
  a_phase_step: assert property (!$past(rst_in) |->
    phase_out == $past(phase_out) + 2'h1)
    else $error("phase did not advance");
  a_end_mark: assert property (cycle_end_out == (phase_out == 2'h3))
    else $error("cycle end misplaced");
  a_read_addr: assert property (phase_out == 2'h1 |->
    rd_addr_out == $past(instr_in[6:0]))
    else $error("wrong read address");
  a_busy_state: assert property (phase_out == 2'h1 |->
    busy_out == ($past(flush_out, 2) || $past(instr_in[13:10]) == 4'h4 ||
    $past(instr_in[13:10]) == 4'h6))
    else $error("busy wrong");
endmodule
bind bcs_bit_ops bcs_bit_ops_chk i_chk (.clk_in, .rst_in, .instr_in, .rd_addr_out, .rd_data_in,
  .file_wr_out, .phase_out, .cycle_end_out, .flush_out, .nop_cycle_out, .busy_out);

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import bcs_pkg::*;
  logic         clk_in = 0, rst_in = 1, flush_out, nop_cycle_out, cycle_end_out, busy_out;
  logic [13:0]  instr_in = 0, w;
  logic [7:0]   rd_data_in = 0;
  logic [6:0]   rd_addr_out;
  logic [1:0]   phase_out;
  logic [31:0]  rs = 32'h9612, r;
  logic [28:0]  e, g;
  bcs_file_wr_t file_wr_out;
  int           n_mismatch = 0, checks_done = 0, skip = 0;
  bcs_bit_ops i_bcs_bit_ops (.clk_in, .rst_in, .instr_in, .rd_addr_out, .rd_data_in,
    .file_wr_out, .phase_out, .cycle_end_out, .flush_out, .nop_cycle_out, .busy_out);
  // ==========
  // Helpers
  function logic [31:0] nx();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task cmp(input logic [28:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========
  // Stimulus
  initial forever #2 clk_in = ~clk_in;
  initial
  begin
    #10000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (5) @(negedge clk_in);
    rst_in = 0;
    for (int i = 0; i < 300; i++)
    begin
      r = nx();
      w = r[13:0];
      // Mostly the two opcodes, sometimes anything else
      if (r[15:14] != 0)
        w[13:10] = {2'h1, r[16], 1'h0};
      if (i == 0)
        w = 14'h1387;
      instr_in = w;
      rd_data_in = (i == 0) ? 8'hC7 : r[31:24];
      e[28:18] = {2'h3, 1'h1, (skip != 0 || w[13:10] == 4'h4 || w[13:10] == 4'h6), w[6:0]};
      e[17] = skip;
      e[16] = !skip && w[13:10] == 4'h6 && !rd_data_in[w[9:7]];
      e[15] = !skip && w[13:10] == 4'h4;
      e[14:0] = e[15] ? {w[6:0], rd_data_in & ~(8'h01 << w[9:7])} : 15'h0;
      repeat (3) @(negedge clk_in);
      g = {phase_out, cycle_end_out, busy_out, rd_addr_out, nop_cycle_out, flush_out,
        file_wr_out.wr, e[15] ? {file_wr_out.addr, file_wr_out.data} : 15'h0};
      cmp(g, e);
      skip = e[16];
      @(negedge clk_in);
    end
    $display("instruction mix done");
    summarize();
  end
endmodule
